/* hw/tsec_map.vh */
/*
 Constants for the two-stage event controller: priority numbers of the
 core stage, source indices of the system stage and default routing.
 Assumes nothing; definitions only.
*/
`ifndef TSEC_MAP_VH
`define TSEC_MAP_VH

// Core stage priorities, 0 highest
`define TSEC_EV_EMU 4'h0
`define TSEC_EV_RST 4'h1
`define TSEC_EV_NMI 4'h2
`define TSEC_EV_EXC 4'h3
`define TSEC_EV_RSV 4'h4
`define TSEC_EV_HWE 4'h5
`define TSEC_EV_TMR 4'h6
`define TSEC_EV_GEN_LO 4'h7
`define TSEC_EV_SW_HI 4'he
`define TSEC_EV_SW_LO 4'hf
`define TSEC_NUM_EV 16
`define TSEC_NUM_SRC 24
`define TSEC_IDLE_PRIO 5'h10

// Default target level for each peripheral source, 4 bits per source.
// Sources 0-6 errors/wakeup, 7 clock, 8 video DMA, 9-12 audio DMA,
// 13-15 SPI/UART DMA, 16-18 timers, 19-20 GPIO, 21-22 mem DMA, 23 wdog
`define TSEC_DEF_ROUTE 96'hddd_cc_bbb_aaa_9999_88_7777777

// Detection latency: edge seen after two synchroniser stages
`define TSEC_SYNC_STAGES 2
`endif

/* hw/tsec_edge_latch.v */
/*
 One event input: two-stage synchroniser, rising edge detector and the
 latch bit that queues the edge until the event enters the pipeline.
 Assumes the input may come from any domain; clear comes from core_clk.
*/
`timescale 1ns/1ps
module tsec_edge_latch (
  input wire core_clk,
  input wire rstn,
  input wire clk_en,
  input wire event_in,
  input wire take,
  input wire sw_clear,
  output reg latch_r
);
  reg sync1_r;
  reg sync2_r;
  reg prev_r;
  wire rise;

  assign rise = sync2_r & ~prev_r;

  // Synchroniser and edge detect, two cycles to see an edge
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (clk_en) begin
      sync1_r <= event_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Latch set on edge; new edge wins over a clear in the same cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      latch_r <= 1'b0;
    end else if (clk_en) begin
      if (rise) begin
        latch_r <= 1'b1;
      end else if (take | sw_clear) begin
        latch_r <= 1'b0;
      end
    end
  end
endmodule

/* hw/tsec_route.v */
/*
 System stage routing of one peripheral source onto one general level.
 Holds the source's assignment field, reset to its default level.
 Assumes writes come from logic on core_clk.
*/
`timescale 1ns/1ps
`include "tsec_map.vh"
module tsec_route #(
  parameter [3:0] DEF_LEVEL = 4'h7
) (
  input wire core_clk,
  input wire rstn,
  input wire clk_en,
  input wire asg_we,
  input wire [3:0] asg_wdata,
  input wire src_on,
  output reg [3:0] level_r,
  output wire [8:0] level_hot
);
  genvar g;

  // Assignment field, default after reset, software may retarget
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      level_r <= DEF_LEVEL;
    end else if (clk_en && asg_we) begin
      level_r <= asg_wdata;
    end
  end

  // Drive the one general level that this source targets
  generate
    for (g = 0; g < 9; g = g + 1) begin : lv
      assign level_hot[g] = src_on &
        (level_r == (`TSEC_EV_GEN_LO + g));
    end
  endgenerate
endmodule

/* hw/tsec_top.v */
/*
 Two-stage event controller. The system stage routes peripheral lines
 onto nine general levels; the core stage latches, masks, prioritises
 and nests those with the dedicated events and hands the winner to the
 sequencer. Assumes the sequencer saves state on the supervisor stack,
 acknowledges dispatch with ack and signals return-from-event with ret.
*/
`timescale 1ns/1ps
`include "tsec_map.vh"
module tsec_top #(
  parameter NSRC = `TSEC_NUM_SRC,
  parameter NEV = `TSEC_NUM_EV
) (
  input wire core_clk,
  input wire rstn,
  input wire clk_en,
  input wire emu_req,
  input wire rst_req,
  input wire nmi_pin,
  input wire wdog_nmi,
  input wire exc_req,
  input wire hw_err,
  input wire core_tmr,
  input wire [1:0] sw_raise,
  input wire [NSRC-1:0] periph_irq,
  input wire [NSRC-1:0] periph_mask,
  input wire asg_we,
  input wire [4:0] asg_sel,
  input wire [3:0] asg_wdata,
  input wire [NEV-1:0] mask_wdata,
  input wire mask_we,
  input wire [NEV-1:0] latch_clr,
  input wire glob_dis,
  input wire ack,
  input wire ret,
  output reg [NEV-1:0] event_latch_bits,
  output reg [NEV-1:0] event_pending_bits,
  output reg [NEV-1:0] core_mask_bits,
  output reg [NSRC-1:0] periph_status,
  output reg disp_valid,
  output reg [3:0] disp_event,
  output reg emu_mode,
  output reg [3:0] ret_class,
  output reg ret_valid
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;
  localparam [NEV-1:0] MASK_FIXED = 16'h000f;
  // Packed default levels, one 4-bit field per source
  localparam [4*NSRC-1:0] DEF_ROUTE = `TSEC_DEF_ROUTE;

  reg state_r;
  reg [NSRC-1:0] irq_s1_r;
  reg [NSRC-1:0] irq_s2_r;
  reg [NEV-1:0] ev_in;
  reg [NEV-1:0] take;
  reg [NEV-1:0] eligible;
  reg [4:0] win;
  reg [4:0] act;
  reg [NEV-1:0] take_nxt;
  reg [NEV-1:0] pend_nxt;
  wire [NEV-1:0] latch_w;
  wire [9*NSRC-1:0] hot_all;
  reg [8:0] gen_lvl;
  integer i;
  integer s;
  genvar gs;
  genvar ge;

  // System stage: one routing slot per peripheral source
  generate
    for (gs = 0; gs < NSRC; gs = gs + 1) begin : src
      tsec_route #(
        .DEF_LEVEL(DEF_ROUTE[4*gs +: 4])
      ) u_route (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .asg_we(asg_we && (asg_sel == gs)),
        .asg_wdata(asg_wdata),
        .src_on(irq_s2_r[gs] & periph_mask[gs]),
        .level_r(),
        .level_hot(hot_all[9*gs +: 9])
      );
    end
  endgenerate

  // Peripheral status view; lines are synchronised before use
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_s1_r <= {NSRC{1'b0}};
      irq_s2_r <= {NSRC{1'b0}};
      periph_status <= {NSRC{1'b0}};
    end else if (clk_en) begin
      irq_s1_r <= periph_irq;
      irq_s2_r <= irq_s1_r;
      periph_status <= irq_s2_r;
    end
  end

  // OR of every source routed onto each general level
  always @* begin
    gen_lvl = 9'h000;
    for (s = 0; s < NSRC; s = s + 1) begin
      gen_lvl = gen_lvl | hot_all[9*s +: 9];
    end
  end

  // Core stage inputs in fixed priority order
  always @* begin
    ev_in = {NEV{1'b0}};
    ev_in[`TSEC_EV_EMU] = emu_req;
    ev_in[`TSEC_EV_RST] = rst_req;
    ev_in[`TSEC_EV_NMI] = nmi_pin | wdog_nmi;
    ev_in[`TSEC_EV_EXC] = exc_req;
    ev_in[`TSEC_EV_HWE] = hw_err;
    ev_in[`TSEC_EV_TMR] = core_tmr;
    ev_in[NEV-1:`TSEC_EV_GEN_LO] = {sw_raise, 7'h00} | gen_lvl;
  end

  // Per-event edge latches; reserved slot never latches
  generate
    for (ge = 0; ge < NEV; ge = ge + 1) begin : ev
      tsec_edge_latch u_latch (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .event_in(ge == `TSEC_EV_RSV ? 1'b0 : ev_in[ge]),
        .take(take[ge]),
        .sw_clear(latch_clr[ge] & ~core_mask_bits[ge]),
        .latch_r(latch_w[ge])
      );
    end
  endgenerate

  // Eligible events: latched and unmasked; general levels obey global off
  always @* begin
    eligible = latch_w & core_mask_bits;
    if (glob_dis) begin
      eligible[NEV-1:`TSEC_EV_GEN_LO] = 9'h000;
    end
  end

  // Lowest-numbered eligible event and highest active priority
  always @* begin
    win = `TSEC_IDLE_PRIO;
    act = `TSEC_IDLE_PRIO;
    for (i = NEV - 1; i >= 0; i = i - 1) begin
      if (eligible[i]) begin
        win = i[4:0];
      end
      if (event_pending_bits[i]) begin
        act = i[4:0];
      end
    end
  end

  // Pending update on accept and on return; latch clears when pending sets
  always @* begin
    take_nxt = {NEV{1'b0}};
    pend_nxt = event_pending_bits;
    if (state_r == ST_WAIT && ack) begin
      take_nxt[disp_event] = 1'b1;
      pend_nxt[disp_event] = 1'b1;
    end
    if (ret && act != `TSEC_IDLE_PRIO) begin
      pend_nxt[act[3:0]] = 1'b0;
    end
  end

  always @* begin
    take = take_nxt;
  end

  // Dispatch handshake with the sequencer
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      disp_valid <= 1'b0;
      disp_event <= 4'h0;
      event_pending_bits <= {NEV{1'b0}};
      ret_valid <= 1'b0;
      ret_class <= 4'h0;
      emu_mode <= 1'b0;
    end else if (clk_en) begin
      event_pending_bits <= pend_nxt;
      ret_valid <= ret && act != `TSEC_IDLE_PRIO;
      if (ret && act != `TSEC_IDLE_PRIO) begin
        ret_class <= act[3:0];
      end
      emu_mode <= pend_nxt[`TSEC_EV_EMU];
      case (state_r)
        ST_IDLE: begin
          if (win < act) begin
            disp_valid <= 1'b1;
            disp_event <= win[3:0];
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ack) begin
            disp_valid <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Mask register; dedicated top events always unmasked
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      core_mask_bits <= MASK_FIXED;
    end else if (clk_en && mask_we) begin
      core_mask_bits <= mask_wdata | MASK_FIXED;
    end
  end

  // Latch view registered for the output
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      event_latch_bits <= {NEV{1'b0}};
    end else if (clk_en) begin
      event_latch_bits <= latch_w;
    end
  end
endmodule

/* tb/tsec_top_sva.sv */
/* Port checker for the event controller.
   Assumes it is bound into tsec_top with clk_en held high. */
`timescale 1ns/1ps
module tsec_top_sva #(
  parameter NEV = 16
) (
  input wire core_clk,
  input wire rstn,
  input wire mask_we,
  input wire [NEV-1:0] mask_wdata,
  input wire [NEV-1:0] core_mask_bits,
  input wire disp_valid,
  input wire [3:0] disp_event,
  input wire ack,
  input wire [NEV-1:0] event_pending_bits,
  input wire glob_dis,
  input wire emu_mode,
  input wire ret_valid,
  input wire [3:0] ret_class
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Steps of one dispatch
  sequence dsp_s;
    $rose(disp_valid);
  endsequence
  sequence acc_s;
    disp_valid && ack;
  endsequence
  mask_write_a: assert property (
    mask_we |=> core_mask_bits == ($past(mask_wdata) | 16'h000f))
    else $error("mask write not taken");
  mask_fixed_a: assert property (
    core_mask_bits[3:0] == 4'hf) else $error("top events masked");
  disp_hold_a: assert property (
    disp_valid && !ack |=> disp_valid && $stable(disp_event))
    else $error("dispatch dropped before ack");
  pend_take_a: assert property (
    acc_s |=> event_pending_bits[$past(disp_event)])
    else $error("accepted event not pending");
  disp_mask_a: assert property (
    dsp_s |-> (($past(core_mask_bits) >> disp_event) & 16'h1) != 0)
    else $error("masked event dispatched");
  disp_prio_a: assert property (
    dsp_s |-> ($past(event_pending_bits) &
    ((17'h2 << disp_event) - 17'h1)) == 0)
    else $error("dispatch not above active events");
  glob_block_a: assert property (
    dsp_s ##0 $past(glob_dis) |-> disp_event < 4'h7)
    else $error("general level dispatched while disabled");
  emu_mode_a: assert property (
    emu_mode == event_pending_bits[0]) else $error("emulation mode wrong");
  ret_pop_a: assert property (
    ret_valid |-> (($past(event_pending_bits) >> ret_class) & 16'h1) != 0
    && !event_pending_bits[ret_class] && ($past(event_pending_bits) &
    ((16'h1 << ret_class) - 16'h1)) == 0)
    else $error("return popped wrong event");
endmodule

/* tb/tsec_seq_model.sv */
/* Sequencer model: accepts each dispatch after a chosen wait.
   Assumes it runs on core_clk beside the controller. */
`timescale 1ns/1ps
module tsec_seq_model (
  input wire core_clk,
  input wire disp_valid,
  input wire [3:0] delay,
  output reg ack
);
  reg [3:0] cnt_r;
  initial begin
    ack = 1'b0;
    cnt_r = 4'h0;
  end
  // Ack pulse after delay cycles; it stands for state saved
  always @(negedge core_clk) begin
    if (ack || disp_valid !== 1'b1) begin
      ack <= 1'b0;
      cnt_r <= 4'h0;
    end else if (cnt_r >= delay) begin
      ack <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

/* tb/tb.sv */
/* Self-checking bench for the event controller.
   Assumes design, checker and sequencer model are compiled first. */
`timescale 1ns/1ps
module tb;
  reg core_clk, rstn, asg_we, mask_we, glob_dis, ret;
  reg [6:0] ded;
  reg [1:0] sw_raise;
  reg [23:0] periph_irq;
  reg [4:0] asg_sel;
  reg [3:0] asg_wdata, delay, lv;
  reg [15:0] mask_wdata;
  reg [31:0] seed;
  integer n_fail, checked, i;
  reg [3:0] exp_q[$];
  wire [15:0] lat, pend, cmask;
  wire disp_valid, emu_mode, ret_valid, ack;
  wire [3:0] disp_event, ret_class;
  wire [23:0] pstat;
  tsec_top dut (.core_clk, .rstn, .clk_en(1'b1), .emu_req(ded[0]),
    .rst_req(ded[1]), .nmi_pin(ded[2]), .exc_req(ded[3]),
    .wdog_nmi(ded[4]), .hw_err(ded[5]), .core_tmr(ded[6]), .sw_raise,
    .periph_irq, .periph_mask(24'hffffff), .asg_we, .asg_sel, .asg_wdata,
    .mask_wdata, .mask_we, .latch_clr(16'h0000), .glob_dis, .ack, .ret,
    .event_latch_bits(lat), .event_pending_bits(pend),
    .core_mask_bits(cmask), .periph_status(pstat), .disp_valid,
    .disp_event, .emu_mode, .ret_class, .ret_valid);
  tsec_seq_model seq (.core_clk, .disp_valid, .delay, .ack);
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function [31:0] rnd(input [31:0] x);
    rnd = x ^ (x << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
  endfunction
  function [3:0] dlev(input integer s);
    dlev = s < 7 ? 7 : s < 9 ? 8 : s < 13 ? 9 : s < 16 ? 10 :
      s < 19 ? 11 : s < 21 ? 12 : 13;
  endfunction
  task chk(input [15:0] got, input [15:0] want);
    begin
      checked = checked + 1;
      if (got !== want) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
    end
  endtask
  task results;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task take(input [3:0] v);
    if (exp_q.size() == 0) chk(v, 16'hffff);
    else chk(v, exp_q.pop_front());
  endtask
  // Result watcher: accepted dispatches and returns in order
  always @(posedge core_clk) begin
    if (disp_valid === 1'b1 && ack === 1'b1) take(disp_event);
    if (ret_valid === 1'b1) take(ret_class);
  end
  task wt(input [3:0] e);
    integer k;
    begin
      for (k = 0; k < 100 && pend[e] !== 1'b1; k = k + 1)
        @(negedge core_clk);
      chk(pend[e], 16'h1);
    end
  endtask
  // Wait for e active, return from it, note the next dispatch
  task serve(input [3:0] e, input [4:0] nx);
    begin
      wt(e);
      chk(emu_mode, e == 4'h0);
      exp_q.push_back(e);
      if (nx < 16) exp_q.push_back(nx[3:0]);
      ret = 1'b1;
      @(negedge core_clk);
      ret = 1'b0;
      repeat (3) @(negedge core_clk);
      chk(pend[e], 16'h0);
    end
  endtask
  task pd(input [6:0] v, input [3:0] e);
    begin
      exp_q.push_back(e);
      ded = v;
      repeat (2) @(negedge core_clk);
      ded = 7'h00;
    end
  endtask
  task pp(input integer s, input [3:0] e);
    begin
      exp_q.push_back(e);
      periph_irq[s] = 1'b1;
      repeat (4) @(negedge core_clk);
      chk(pstat[s], 16'h1);
      periph_irq[s] = 1'b0;
    end
  endtask
  initial begin
    #2000000;
    n_fail = n_fail + 1;
    results;
  end
  // Main sequence
  initial begin
    {rstn, asg_we, mask_we, glob_dis, ret, ded, sw_raise} = 0;
    {periph_irq, asg_sel, asg_wdata, mask_wdata} = 0;
    {n_fail, checked} = 0;
    delay = 4'h8;
    seed = 32'd47;
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk(cmask, 16'h000f);
    chk(pend, 16'h0000);
    // Unmask hardware error and core timer, general levels stay masked
    mask_wdata = 16'h0060;
    mask_we = 1'b1;
    @(negedge core_clk);
    mask_we = 1'b0;
    $display("test reset ended");
    exp_q.push_back(4'h3);
    ded[3] = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(pend[3], 16'h0);
    repeat (2) @(negedge core_clk);
    chk(lat[3], 16'h1);
    ded[3] = 1'b0;
    serve(4'h3, 5'h10);
    pd(7'h6c, 4'h2);
    serve(4'h2, 5'h03);
    serve(4'h3, 5'h05);
    serve(4'h5, 5'h06);
    serve(4'h6, 5'h10);
    $display("test latency and priority ended");
    delay = 4'h0;
    for (i = 0; i < 7; i = i + 1) begin
      lv = i == 4 ? 4'h2 : i;
      pd(7'h01 << i, lv);
      serve(lv, 5'h10);
    end
    pd(7'h40, 4'h6);
    wt(4'h6);
    pd(7'h08, 4'h3);
    serve(4'h3, 5'h10);
    serve(4'h6, 5'h10);
    $display("test classes and nesting ended");
    pp(16, 4'hb);
    repeat (8) @(negedge core_clk);
    chk(lat[11], 16'h1);
    chk(disp_valid, 16'h0);
    mask_wdata = 16'hfff0;
    mask_we = 1'b1;
    @(negedge core_clk);
    mask_we = 1'b0;
    serve(4'hb, 5'h10);
    glob_dis = 1'b1;
    pd(7'h40, 4'h6);
    serve(4'h6, 5'h10);
    pp(0, 4'h7);
    repeat (8) @(negedge core_clk);
    chk(disp_valid, 16'h0);
    glob_dis = 1'b0;
    serve(4'h7, 5'h10);
    $display("test mask ended");
    for (i = 0; i < 24; i = i + 1) begin
      pp(i, dlev(i));
      serve(dlev(i), 5'h10);
    end
    for (i = 0; i < 2; i = i + 1) begin
      exp_q.push_back(4'he + i);
      sw_raise = i + 1;
      repeat (2) @(negedge core_clk);
      sw_raise = 2'b00;
      serve(4'he + i, 5'h10);
    end
    $display("test routing ended");
    for (i = 0; i < 6; i = i + 1) begin
      seed = rnd(seed);
      asg_sel = seed % 24;
      lv = 7 + (seed >> 8) % 9;
      asg_wdata = lv;
      asg_we = 1'b1;
      @(negedge core_clk);
      asg_we = 1'b0;
      pp(asg_sel, lv);
      serve(lv, 5'h10);
    end
    $display("test reassign ended");
    results;
  end
endmodule
bind tsec_top tsec_top_sva #(.NEV(NEV)) sva (.core_clk, .rstn, .mask_we,
  .mask_wdata, .core_mask_bits, .disp_valid, .disp_event, .ack,
  .event_pending_bits, .glob_dis, .emu_mode, .ret_valid, .ret_class);
